// file: design/fpes_pkg.sv
// package: register map, field layout and timing of the flash program/erase sequencer
package fpes_pkg;

	// ----------------------------------------------------------------
	// bus and register map
	// ----------------------------------------------------------------
	localparam int ADR_W = 8;
	localparam int DAT_W = 32;
	localparam int SEL_W = 4;
	localparam logic [ADR_W-1:0] OFS_COMMAND = 8'h04;
	localparam logic [ADR_W-1:0] OFS_PROG_DATA = 8'h08;
	localparam logic [ADR_W-1:0] OFS_PROG_ADDR = 8'h10;
	localparam logic [DAT_W-1:0] RST_COMMAND = 32'h0000_0000;
	localparam logic [DAT_W-1:0] RST_PROG_DATA = 32'h0000_0000;
	localparam logic [DAT_W-1:0] RST_PROG_ADDR = 32'h0000_0000;
	localparam logic [DAT_W-1:0] READ_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CMD_STANDBY_BIT = 0;
	localparam int CMD_WORD_PROGRAM_BIT = 1;
	localparam int CMD_MASS_ERASE_BIT = 2;
	localparam int CMD_PAGE_ERASE_BIT = 3;
	localparam int CMD_GO_LSB = 1;
	localparam int CMD_GO_W = 3;
	localparam int INFO_BIT = 16;
	localparam int HADDR_W = 15;
	localparam int PAGE_LSB = 9;
	localparam int INFO_PAGE_MSB = 11;
	localparam int WORD_LSB = 2;
	localparam int ADDR_REG_W = 17;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam longint CLK_PERIOD_PS = 8000;
	localparam longint PROG_MIN_PS = 64'd30_000_000;
	localparam longint ERASE_MIN_PS = 64'd40_000_000_000;
	localparam int TIMER_W = 23;
	// least times round up to whole clock cycles
	localparam int PROG_CYCLES = int'((PROG_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int ERASE_CYCLES = int'((ERASE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		FPES_OP_NONE = 2'b00,
		FPES_OP_PROGRAM = 2'b01,
		FPES_OP_MASS = 2'b10,
		FPES_OP_PAGE = 2'b11
	} fpes_op_t;

	typedef enum logic [1:0] {
		FPES_ST_IDLE = 2'b00,
		FPES_ST_SETUP = 2'b01,
		FPES_ST_ACTIVE = 2'b10,
		FPES_ST_RECOVER = 2'b11
	} fpes_state_t;

endpackage : fpes_pkg

// file: design/fpes_timer.sv
// file: load-and-count-down timer that times one flash macro operation
`timescale 1ns/1ns
module fpes_timer
	import fpes_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control
	input wire logic load_i,
	input wire logic [TIMER_W-1:0] count_i,
	// status
	output logic fire_o
);

	typedef struct packed {
		logic [TIMER_W-1:0] cnt;
		logic run;
		logic fire;
	} fpes_tmr_t;

	localparam logic [TIMER_W-1:0] ONE = 23'h00_0001;

	fpes_tmr_t s_q;
	fpes_tmr_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.fire = 1'b0;
		if (load_i) begin
			s_d.cnt = count_i;
			s_d.run = 1'b1;
		end else if (s_q.run) begin
			// fire in the last counted cycle, so count_i cycles elapse from load
			if (s_q.cnt <= ONE) begin
				s_d.run = 1'b0;
				s_d.fire = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt - ONE;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign fire_o = s_q.fire;

endmodule : fpes_timer

// file: design/fpes_top.sv
// file: flash program/erase sequencer with classic Wishbone register slave
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ns

// Notes on behaviour
// - page-erase bit erases addressed main or info page, self-clears, lasts at least 40 ms
// - mass-erase bit erases whole main array, self-clears, lasts at least 40 ms
// - program bit writes data register word at address, lasting about 30-40 us
// - standby bit, readable and writable, puts flash in standby with system
// - program data register is 32-bit read/write, resets to zero
// - address bit 16 selects information block for program and page erase
// - 15-bit byte address on 512-byte pages; mass erase ignores it
// - main page erase uses address bits 14:9, 64 pages
// - info page erase uses bits 11:9, 8 pages, ignores others
// - word program uses address bits 14:2, ignores bits 1:0
// - flash accesses and fetches are held off while an operation runs
module fpes_top
	import fpes_pkg::*;
#(
	parameter int unsigned ERASE_TIME_CYCLES = ERASE_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [SEL_W-1:0] wb_sel_i,
	input wire logic [DAT_W-1:0] wb_dat_i,
	output logic [DAT_W-1:0] wb_dat_o,
	output logic wb_ack_o,
	// system
	input wire logic sys_sleep_i,
	output logic fetch_hold_o,
	// flash macro
	output logic [HADDR_W-1:0] flash_addr_o,
	output logic [DAT_W-1:0] flash_wdata_o,
	output logic flash_info_o,
	output logic flash_prog_o,
	output logic flash_page_erase_o,
	output logic flash_mass_erase_o,
	output logic flash_standby_o
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic ack;
		logic [DAT_W-1:0] rdata;
		logic standby_bit;
		logic [CMD_GO_W-1:0] go;
		logic [DAT_W-1:0] pdata;
		logic [ADDR_REG_W-1:0] paddr;
		fpes_state_t state;
		fpes_op_t op;
		logic hold;
		logic [HADDR_W-1:0] f_addr;
		logic [DAT_W-1:0] f_wdata;
		logic f_info;
		logic f_prog;
		logic f_page;
		logic f_mass;
		logic f_standby;
	} fpes_regs_t;

	localparam logic [TIMER_W-1:0] PROG_LOAD = TIMER_W'(PROG_CYCLES);
	localparam logic [TIMER_W-1:0] ERASE_LOAD = TIMER_W'(ERASE_TIME_CYCLES);

	fpes_regs_t r_q;
	fpes_regs_t r_d;
	logic tmr_load;
	logic [TIMER_W-1:0] tmr_count;
	logic tmr_fire;
	logic bus_req;
	logic bus_wr;
	logic [DAT_W-1:0] cmd_wr;
	logic [DAT_W-1:0] data_wr;
	logic [DAT_W-1:0] addr_wr;
	logic [CMD_GO_W-1:0] go_req;
	fpes_op_t new_op;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// merge write data into a register under the byte selects
	function automatic logic [DAT_W-1:0] merge_sel(
		input logic [DAT_W-1:0] old_v,
		input logic [DAT_W-1:0] new_v,
		input logic [SEL_W-1:0] sel
	);
		logic [DAT_W-1:0] res;
		res = old_v;
		for (int i = 0; i < SEL_W; i++) begin
			if (sel[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction : merge_sel

	// byte address handed to the macro, with the don't-care bits of each operation forced low
	function automatic logic [HADDR_W-1:0] op_address(
		input fpes_op_t op,
		input logic info,
		input logic [HADDR_W-1:0] haddr
	);
		logic [HADDR_W-1:0] res;
		res = '0;
		case (op)
			FPES_OP_PROGRAM: begin
				res[HADDR_W-1:WORD_LSB] = haddr[HADDR_W-1:WORD_LSB];
			end
			FPES_OP_PAGE: begin
				if (info) begin
					res[INFO_PAGE_MSB:PAGE_LSB] = haddr[INFO_PAGE_MSB:PAGE_LSB];
				end else begin
					res[HADDR_W-1:PAGE_LSB] = haddr[HADDR_W-1:PAGE_LSB];
				end
			end
			FPES_OP_MASS: begin
				res = '0;
			end
			default: begin
				res = '0;
			end
		endcase
		return res;
	endfunction : op_address

	// one operation at a time; page erase outranks mass erase outranks program
	function automatic fpes_op_t pick_op(
		input logic [CMD_GO_W-1:0] go
	);
		fpes_op_t res;
		res = FPES_OP_NONE;
		if (go[CMD_PAGE_ERASE_BIT - CMD_GO_LSB]) begin
			res = FPES_OP_PAGE;
		end else if (go[CMD_MASS_ERASE_BIT - CMD_GO_LSB]) begin
			res = FPES_OP_MASS;
		end else if (go[CMD_WORD_PROGRAM_BIT - CMD_GO_LSB]) begin
			res = FPES_OP_PROGRAM;
		end
		return res;
	endfunction : pick_op

	// readable go bit that stands for an operation while it runs
	function automatic logic [CMD_GO_W-1:0] op_go_bit(
		input fpes_op_t op
	);
		logic [CMD_GO_W-1:0] res;
		res = '0;
		case (op)
			FPES_OP_PROGRAM: begin
				res[CMD_WORD_PROGRAM_BIT - CMD_GO_LSB] = 1'b1;
			end
			FPES_OP_MASS: begin
				res[CMD_MASS_ERASE_BIT - CMD_GO_LSB] = 1'b1;
			end
			FPES_OP_PAGE: begin
				res[CMD_PAGE_ERASE_BIT - CMD_GO_LSB] = 1'b1;
			end
			default: begin
				res = '0;
			end
		endcase
		return res;
	endfunction : op_go_bit

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	// a request is taken once; ack drops in the cycle after it was given
	// registered ack costs one wait state but keeps the bus path short
	assign bus_req = wb_cyc_i && wb_stb_i && !r_q.ack;
	assign bus_wr = bus_req && wb_we_i;
	assign cmd_wr = (bus_wr && wb_adr_i == OFS_COMMAND) ? wb_dat_i : READ_ZERO;
	assign data_wr = merge_sel(r_q.pdata, wb_dat_i, wb_sel_i);
	assign addr_wr = merge_sel(DAT_W'(r_q.paddr), wb_dat_i, wb_sel_i);
	// command bits all sit in the lowest byte lane
	assign go_req = wb_sel_i[0] ? cmd_wr[CMD_GO_LSB +: CMD_GO_W] : '0;
	// operation asked for by this write, after priority
	assign new_op = pick_op(go_req);

	// ----------------------------------------------------------------
	// operation timer
	// ----------------------------------------------------------------
	// loaded in the setup cycle, on the same edge as the strobe rises
	// the strobe then stands one cycle longer than loaded, never shorter than the least time
	assign tmr_load = (r_q.state == FPES_ST_SETUP);
	assign tmr_count = (r_q.op == FPES_OP_PROGRAM) ? PROG_LOAD : ERASE_LOAD;

	fpes_timer u_fpes_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.load_i(tmr_load),
		.count_i(tmr_count),
		.fire_o(tmr_fire)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		r_d = r_q;
		r_d.ack = bus_req;

		// register writes
		if (bus_wr) begin
			case (wb_adr_i)
				OFS_COMMAND: begin
					if (wb_sel_i[0]) begin
						r_d.standby_bit = wb_dat_i[CMD_STANDBY_BIT];
					end
				end
				OFS_PROG_DATA: begin
					r_d.pdata = data_wr;
				end
				OFS_PROG_ADDR: begin
					r_d.paddr = addr_wr[ADDR_REG_W-1:0];
					r_d.paddr[HADDR_W] = 1'b0;
				end
				default: begin
					r_d.paddr = r_q.paddr;
				end
			endcase
		end

		// register reads; unmapped addresses read as zero
		if (bus_req) begin
			case (wb_adr_i)
				OFS_COMMAND: begin
					r_d.rdata = READ_ZERO;
					r_d.rdata[CMD_STANDBY_BIT] = r_q.standby_bit;
					r_d.rdata[CMD_GO_LSB +: CMD_GO_W] = r_q.go;
				end
				OFS_PROG_DATA: begin
					r_d.rdata = r_q.pdata;
				end
				OFS_PROG_ADDR: begin
					r_d.rdata = DAT_W'(r_q.paddr);
				end
				default: begin
					r_d.rdata = READ_ZERO;
				end
			endcase
		end

		// sequencer
		case (r_q.state)
			FPES_ST_IDLE: begin
				if (new_op != FPES_OP_NONE) begin
					r_d.state = FPES_ST_SETUP;
					r_d.hold = 1'b1;
					r_d.op = new_op;
					r_d.go = op_go_bit(new_op);
					r_d.f_wdata = r_q.pdata;
					// info block for program and page erase, never for mass erase
					r_d.f_info = r_q.paddr[INFO_BIT] && (new_op != FPES_OP_MASS);
					r_d.f_addr = op_address(new_op, r_q.paddr[INFO_BIT],
						r_q.paddr[HADDR_W-1:0]);
				end
			end
			// address and data settle one cycle before the strobe
			FPES_ST_SETUP: begin
				r_d.state = FPES_ST_ACTIVE;
				r_d.f_prog = (r_q.op == FPES_OP_PROGRAM);
				r_d.f_page = (r_q.op == FPES_OP_PAGE);
				r_d.f_mass = (r_q.op == FPES_OP_MASS);
			end
			// new command bits ignored until back in idle
			FPES_ST_ACTIVE: begin
				if (tmr_fire) begin
					r_d.state = FPES_ST_RECOVER;
					r_d.f_prog = 1'b0;
					r_d.f_page = 1'b0;
					r_d.f_mass = 1'b0;
				end
			end
			// command bit clears itself when the flow ends
			FPES_ST_RECOVER: begin
				r_d.state = FPES_ST_IDLE;
				r_d.go = '0;
				r_d.op = FPES_OP_NONE;
				r_d.hold = 1'b0;
			end
			default: begin
				r_d.state = FPES_ST_IDLE;
				r_d.go = '0;
				r_d.op = FPES_OP_NONE;
				r_d.hold = 1'b0;
				r_d.f_prog = 1'b0;
				r_d.f_page = 1'b0;
				r_d.f_mass = 1'b0;
			end
		endcase

		// standby only together with the system and never mid-operation
		r_d.f_standby = r_d.standby_bit && sys_sleep_i && (r_d.state == FPES_ST_IDLE);
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			r_q <= '0;
			r_q.pdata <= RST_PROG_DATA;
			r_q.paddr <= RST_PROG_ADDR[ADDR_REG_W-1:0];
			r_q.standby_bit <= RST_COMMAND[CMD_STANDBY_BIT];
			r_q.go <= RST_COMMAND[CMD_GO_LSB +: CMD_GO_W];
			r_q.state <= FPES_ST_IDLE;
			r_q.op <= FPES_OP_NONE;
		end else begin
			r_q <= r_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign wb_ack_o = r_q.ack;
	assign wb_dat_o = r_q.rdata;
	assign fetch_hold_o = r_q.hold;
	assign flash_addr_o = r_q.f_addr;
	assign flash_wdata_o = r_q.f_wdata;
	assign flash_info_o = r_q.f_info;
	assign flash_prog_o = r_q.f_prog;
	assign flash_page_erase_o = r_q.f_page;
	assign flash_mass_erase_o = r_q.f_mass;
	assign flash_standby_o = r_q.f_standby;

endmodule : fpes_top

// file: test/fpes_chk.sv
// checker: port-level assertions for the flash sequencer
`timescale 1ns/1ns
module fpes_chk
	import fpes_pkg::*;
#(
	parameter int unsigned ERASE_TIME_CYCLES = ERASE_CYCLES
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADR_W-1:0] wb_adr_i,
	input wire logic [SEL_W-1:0] wb_sel_i,
	input wire logic [DAT_W-1:0] wb_dat_i,
	input wire logic [DAT_W-1:0] wb_dat_o,
	input wire logic wb_ack_o,
	// system
	input wire logic sys_sleep_i,
	input wire logic fetch_hold_o,
	// flash macro
	input wire logic [HADDR_W-1:0] flash_addr_o,
	input wire logic [DAT_W-1:0] flash_wdata_o,
	input wire logic flash_info_o,
	input wire logic flash_prog_o,
	input wire logic flash_page_erase_o,
	input wire logic flash_mass_erase_o,
	input wire logic flash_standby_o
);
	logic strb;
	logic [22:0] run_q;
	assign strb = flash_prog_o | flash_page_erase_o | flash_mass_erase_o;
	// length of the current strobe, compared when it falls
	always_ff @(posedge clk_i) begin
		run_q <= (rst_i || !strb) ? 23'h0 : run_q + 23'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack: assert property (p_ack) else $error("ack missing");
	property p_ack1; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("ack too long");
	property p_one; $onehot0({flash_prog_o, flash_page_erase_o, flash_mass_erase_o}); endproperty
	a_one: assert property (p_one) else $error("two strobes");
	property p_hold; strb |-> fetch_hold_o; endproperty
	a_hold: assert property (p_hold) else $error("fetch not held");
	property p_end; $fell(strb) |-> fetch_hold_o ##1 !fetch_hold_o; endproperty
	a_end: assert property (p_end) else $error("hold end wrong");
	property p_len;
		$fell(strb) |-> run_q == ($past(flash_prog_o) ? PROG_CYCLES + 1 : ERASE_TIME_CYCLES + 1);
	endproperty
	a_len: assert property (p_len) else $error("op length wrong");
	property p_mass; flash_mass_erase_o |-> !flash_info_o && flash_addr_o == 15'h0; endproperty
	a_mass: assert property (p_mass) else $error("mass addr");
	property p_page;
		flash_page_erase_o |-> flash_addr_o[8:0] == 9'h0
			&& !(flash_info_o && flash_addr_o[14:12] != 3'h0);
	endproperty
	a_page: assert property (p_page) else $error("page addr");
	property p_word; flash_prog_o |-> flash_addr_o[1:0] == 2'h0; endproperty
	a_word: assert property (p_word) else $error("word addr");
	property p_stab; strb && $past(strb) |-> $stable(flash_addr_o) && $stable(flash_wdata_o); endproperty
	a_stab: assert property (p_stab) else $error("op changed");
	property p_stby; flash_standby_o |-> $past(sys_sleep_i) && !strb; endproperty
	a_stby: assert property (p_stby) else $error("standby wrong");
	c_prog: cover property ($fell(flash_prog_o));
	c_page: cover property ($fell(flash_page_erase_o));
	c_mass: cover property ($fell(flash_mass_erase_o));
endmodule : fpes_chk

// file: test/fpes_flash_model.sv
// partner: passive flash macro that records each operation it receives
`timescale 1ns/1ns
module fpes_flash_model
	import fpes_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// from sequencer
	input wire logic [HADDR_W-1:0] addr_i,
	input wire logic [DAT_W-1:0] wdata_i,
	input wire logic info_i,
	input wire logic prog_i,
	input wire logic page_i,
	input wire logic mass_i,
	input wire logic hold_i,
	// record
	output logic [2:0] op_o,
	output logic [HADDR_W-1:0] addr_o,
	output logic [DAT_W-1:0] data_o,
	output logic info_o,
	output logic [22:0] len_o,
	output logic hold_ok_o
);
	logic busy;
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			{busy, op_o, addr_o, data_o, info_o, len_o} <= '0;
			hold_ok_o <= 1'b1;
		end else if (prog_i | page_i | mass_i) begin
			// the array is only taken at the start of an operation
			if (!busy) begin
				{op_o, addr_o, data_o, info_o} <= {page_i, mass_i, prog_i, addr_i, wdata_i, info_i};
			end
			len_o <= busy ? len_o + 23'h1 : 23'h1;
			busy <= 1'b1;
			if (!hold_i) hold_ok_o <= 1'b0;
		end else begin
			busy <= 1'b0;
		end
	end
endmodule : fpes_flash_model

// file: test/fpes_top_tb.sv
// testbench: register and flash operation scenarios for the sequencer
`timescale 1ns/1ns
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin mismatches++; \
	$display("ERROR %s expected %h seen %h", n, e, a); end end
module fpes_top_tb;
	import fpes_pkg::*;
	logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ack, sleep = 0, hold, info;
	logic prog, page, mass, stby, m_info, m_ok;
	logic [7:0] adr = 8'h0;
	logic [3:0] sel = 4'h0;
	logic [31:0] dat = 32'h0, dato, wdat, m_data, q;
	logic [14:0] faddr, m_addr;
	logic [2:0] m_op;
	logic [22:0] m_len;
	int mismatches = 0, check_count = 0;
	always #4 clk_i = ~clk_i;
	fpes_top #(.ERASE_TIME_CYCLES(20)) u_fpes_top (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(dat), .wb_dat_o(dato), .wb_ack_o(ack), .sys_sleep_i(sleep),
		.fetch_hold_o(hold), .flash_addr_o(faddr), .flash_wdata_o(wdat), .flash_info_o(info),
		.flash_prog_o(prog), .flash_page_erase_o(page), .flash_mass_erase_o(mass),
		.flash_standby_o(stby));
	fpes_flash_model u_fpes_flash_model (.clk_i(clk_i), .rst_i(rst_i), .addr_i(faddr),
		.wdata_i(wdat), .info_i(info), .prog_i(prog), .page_i(page), .mass_i(mass),
		.hold_i(hold), .op_o(m_op), .addr_o(m_addr), .data_o(m_data), .info_o(m_info),
		.len_o(m_len), .hold_ok_o(m_ok));
	task tally_and_finish;
		if (mismatches == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	task wb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
		int n;
		n = 0;
		@(posedge clk_i);
		{cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
		do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
		q = dato;
		{cyc, stb} <= 2'b00;
		if (n >= 50) begin mismatches++; tally_and_finish(); end
	endtask : wb
	task run_op(input logic [3:0] cmd);
		int n;
		n = 0;
		wb(8'h04, 1, {28'h0, cmd}, 4'h1);
		`CHK("hold", 1'b1, hold)
		wb(8'h04, 0, 32'h0, 4'hF);
		`CHK("go", cmd[3:1], q[3:1])
		wb(8'h04, 1, 32'h8, 4'h1);
		do begin wb(8'h04, 0, 32'h0, 4'hF); n++; end while (q[3:1] !== 3'h0 && n < 2000);
		if (n >= 2000) begin mismatches++; tally_and_finish(); end
		`CHK("held", 1'b1, m_ok)
	endtask : run_op
	task t_regs;
		wb(8'h08, 0, 32'h0, 4'hF); `CHK("data rst", RST_PROG_DATA, q)
		wb(8'h10, 0, 32'h0, 4'hF); `CHK("addr rst", RST_PROG_ADDR, q)
		wb(8'h08, 1, 32'hFFFF_FFFF, 4'hF);
		wb(8'h08, 1, 32'h0, 4'h1);
		wb(8'h08, 0, 32'h0, 4'hF); `CHK("data rw", 32'hFFFF_FF00, q)
		wb(8'h10, 1, 32'hFFFF_FFFF, 4'hF);
		wb(8'h10, 0, 32'h0, 4'hF); `CHK("addr rw", 32'h0001_7FFF, q)
		wb(8'h0C, 1, 32'h1234_5678, 4'hF);
		wb(8'h0C, 0, 32'h0, 4'hF); `CHK("unmapped", 32'h0, q)
	endtask : t_regs
	task t_program;
		// data, then address, then command, then poll
		wb(8'h08, 1, 32'hA5A5_5A5A, 4'hF);
		wb(8'h10, 1, 32'h0000_1237, 4'hF);
		run_op(4'h2);
		`CHK("p op", 3'b001, m_op)
		`CHK("p addr", 15'h1234, m_addr)
		`CHK("p data", 32'hA5A5_5A5A, m_data)
		`CHK("p len", 23'd3751, m_len)
		`CHK("p info", 1'b0, m_info)
	endtask : t_program
	task t_erase;
		wb(8'h10, 1, 32'h0001_7FFF, 4'hF);
		run_op(4'h8);
		`CHK("ie addr", 15'h0E00, m_addr)
		`CHK("ie info", 1'b1, m_info)
		`CHK("ie len", 23'd21, m_len)
		wb(8'h10, 1, 32'h0000_7FFF, 4'hF);
		run_op(4'h8);
		`CHK("pe op", 3'b100, m_op)
		`CHK("pe addr", 15'h7E00, m_addr)
		`CHK("pe info", 1'b0, m_info)
	endtask : t_erase
	task t_mass;
		wb(8'h10, 1, 32'h0001_7FFF, 4'hF);
		run_op(4'h4);
		`CHK("me op", 3'b010, m_op)
		`CHK("me addr", 15'h0, m_addr)
		`CHK("me len", 23'd21, m_len)
		`CHK("me info", 1'b0, m_info)
	endtask : t_mass
	task t_standby;
		wb(8'h04, 1, 32'h1, 4'h1);
		sleep <= 1'b1;
		repeat (3) @(posedge clk_i);
		`CHK("standby", 1'b1, stby)
		wb(8'h04, 0, 32'h0, 4'hF); `CHK("sleep bit", 32'h1, q)
		sleep <= 1'b0;
		repeat (3) @(posedge clk_i);
		`CHK("awake", 1'b0, stby)
	endtask : t_standby
	initial begin
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_regs();
		t_program();
		t_erase();
		t_mass();
		t_standby();
		tally_and_finish();
	end
endmodule : fpes_top_tb
bind fpes_top fpes_chk #(.ERASE_TIME_CYCLES(ERASE_TIME_CYCLES)) u_fpes_chk (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i),
	.wb_dat_i(wb_dat_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.sys_sleep_i(sys_sleep_i),
	.fetch_hold_o(fetch_hold_o),
	.flash_addr_o(flash_addr_o),
	.flash_wdata_o(flash_wdata_o),
	.flash_info_o(flash_info_o),
	.flash_prog_o(flash_prog_o),
	.flash_page_erase_o(flash_page_erase_o),
	.flash_mass_erase_o(flash_mass_erase_o),
	.flash_standby_o(flash_standby_o)
);
